// ### rtl/gqw_pkg.sv
// package: constants and types for the gpio input qualifier and wake block
package gqw_pkg;
  localparam int          GQW_GROUP_PINS   = 8;
  localparam int          GQW_PRD_W        = 8;
  localparam int          GQW_STBY_W       = 6;
  localparam int          GQW_CNT_W        = 9;
  localparam int          GQW_LAT_W        = 11;
  localparam int          GQW_SAMPLES_3    = 3;
  localparam int          GQW_SAMPLES_6    = 6;
  localparam int          GQW_CLK_NS       = 25;
  localparam int          GQW_OSC_DIV      = 2;
  localparam int          GQW_LPM_GUARD    = 4;
  localparam int          GQW_STBY_BASE    = 2;
  localparam int          GQW_STBY_UNQ     = 3;
  localparam logic [10:0] GQW_LAT_FAST     = 11'h014;
  localparam logic [10:0] GQW_LAT_SLEEP    = 11'h41a;
  localparam logic [10:0] GQW_WAKE_PIPE    = 11'h004;
  localparam logic [8:0]  GQW_CNT_RST      = 9'h000;

  typedef enum logic [1:0] {
    GQW_RUN   = 2'b00,
    GQW_IDLE  = 2'b01,
    GQW_STBY  = 2'b10,
    GQW_WAKE  = 2'b11
  } gqw_mode_e;
endpackage

// ### rtl/gqw_qual_group.sv
// module: qualifier for one group of eight pins sharing one period
`timescale 1ns/10ps
module gqw_qual_group
  import gqw_pkg::*;
#(
  parameter int PINS = gqw_pkg::GQW_GROUP_PINS
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic [PINS-1:0]               pin_sync,
  input  wire logic [gqw_pkg::GQW_PRD_W-1:0] qual_period_field,
  input  wire logic [PINS-1:0]               qual_six,
  output logic      [PINS-1:0]               qual_out,
  output logic                               sample_tick
);
  import gqw_pkg::*;

  if (PINS < 1) begin : bad_pins
    $error("gqw_qual_group: PINS must be positive");
  end

  typedef struct packed {
    logic [GQW_CNT_W-1:0] cnt;
    logic                 tick;
    logic [PINS-1:0][5:0] hist;
    logic [PINS-1:0]      q;
  } gqw_grp_s;

  gqw_grp_s st;
  gqw_grp_s next_st;
  logic [GQW_CNT_W-1:0] limit;

  // one sample per 2n clocks, or every clock when n is zero
  assign limit = (qual_period_field == '0) ? GQW_CNT_RST :
                 GQW_CNT_W'({qual_period_field, 1'b0} - 9'h001);

  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt >= limit) begin
      next_st.cnt  = GQW_CNT_RST;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 9'h001;
    end
    for (int i = 0; i < PINS; i++) begin
      if (next_st.tick) begin
        next_st.hist[i] = {st.hist[i][4:0], pin_sync[i]};
      end
      // output moves only when every sample in the window agrees
      if (qual_six[i]) begin
        if (&st.hist[i]) next_st.q[i] = 1'b1;
        else if (~|st.hist[i]) next_st.q[i] = 1'b0;
      end else begin
        if (&st.hist[i][2:0]) next_st.q[i] = 1'b1;
        else if (~|st.hist[i][2:0]) next_st.q[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign qual_out    = st.q;
  assign sample_tick = st.tick;

  three_agree_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!qual_six[0] && st.hist[0][2:0] == 3'h7)
      |=> st.q[0])
    else $error("three equal high samples did not set output");
  six_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (qual_six[0] && st.hist[0] != 6'h3f && st.hist[0] != 6'h00)
      |=> $stable(st.q[0]))
    else $error("output changed without sample agreement");
  zero_period_a: assert property (@(posedge sys_clk) disable iff (rst)
    (qual_period_field == 8'h00 && $past(qual_period_field) == 8'h00
     && !$past(rst)) |-> st.tick)
    else $error("period zero missed a sample");
  tick_space_a: assert property (@(posedge sys_clk) disable iff (rst)
    (qual_period_field == 8'h01 && st.tick) |=> !st.tick ##1 st.tick)
    else $error("period one did not sample every two cycles");
endmodule

// ### rtl/gqw_top.sv
// module: gpio input qualifier with low-power wake timing
`timescale 1ns/10ps
module gqw_top
  import gqw_pkg::*;
#(
  parameter int GROUPS = 1
) (
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  input  wire logic [GROUPS*gqw_pkg::GQW_GROUP_PINS-1:0] gpio_pin,
  input  wire logic [GROUPS*gqw_pkg::GQW_PRD_W-1:0] qual_period_field,
  input  wire logic [GROUPS*gqw_pkg::GQW_GROUP_PINS-1:0] qual_sample_select_reg,
  input  wire logic [GROUPS*gqw_pkg::GQW_GROUP_PINS-1:0] qual_enable,
  input  wire logic [gqw_pkg::GQW_STBY_W-1:0]     standby_qual_count,
  input  wire logic                               idle_enter,
  input  wire logic                               standby_sel,
  input  wire logic                               flash_sleep,
  input  wire logic                               int_wake,
  input  wire logic                               watchdog_wake_int,
  input  wire logic                               nonmaskable_ext_int,
  input  wire logic                               device_reset_pin,
  input  wire logic [GROUPS*gqw_pkg::GQW_GROUP_PINS-1:0] wake_pin_sel,
  output logic      [GROUPS*gqw_pkg::GQW_GROUP_PINS-1:0] gpio_in,
  output logic                                    lpm_active,
  output logic                                    resume
);
  import gqw_pkg::*;

  localparam int NP = GROUPS * GQW_GROUP_PINS;

  if (GROUPS < 1) begin : bad_groups
    $error("gqw_top: GROUPS must be positive");
  end

  typedef struct packed {
    logic [NP-1:0]           s1;
    logic [NP-1:0]           s2;
    logic [3:0]              ext1;
    logic [3:0]              ext2;
    logic [NP-1:0]           gin;
    gqw_mode_e               mode;
    logic [GQW_LAT_W-1:0]    lat;
    logic [GQW_STBY_W:0]     wcnt;
    logic                    osc_en;
    logic                    osc_ph;
    logic [2:0]              guard;
    logic                    resume;
    logic                    lpm;
  } gqw_top_s;

  gqw_top_s st;
  gqw_top_s next_st;
  logic [NP-1:0] qual_q;
  logic [NP-1:0] unq_q;
  logic [NP-1:0] sel_pins;
  logic          pin_wake;
  logic          other_wake;
  logic [GQW_STBY_W:0] stby_need;

  // sync and decode stages before wake entry count against the limit
  function automatic logic [GQW_LAT_W-1:0] wake_lat(input logic sleep);
    wake_lat = (sleep ? GQW_LAT_SLEEP : GQW_LAT_FAST) - GQW_WAKE_PIPE;
  endfunction

  for (genvar g = 0; g < GROUPS; g++) begin : grp
    gqw_qual_group #(
      .PINS (GQW_GROUP_PINS)
    ) u_grp (
      .sys_clk           (sys_clk),
      .rst               (rst),
      .pin_sync          (st.s2[g*GQW_GROUP_PINS +: GQW_GROUP_PINS]),
      .qual_period_field (qual_period_field[g*GQW_PRD_W +: GQW_PRD_W]),
      .qual_six          (qual_sample_select_reg[g*GQW_GROUP_PINS +:
                                                 GQW_GROUP_PINS]),
      .qual_out          (qual_q[g*GQW_GROUP_PINS +: GQW_GROUP_PINS]),
      .sample_tick       ()
    );
  end

  // unqualified pins use the synchronised level directly
  assign unq_q    = st.s2;
  assign sel_pins = st.gin & wake_pin_sel;
  assign pin_wake = |sel_pins;
  assign other_wake = st.ext2[0] | st.ext2[1] | st.ext2[2] | st.ext2[3];
  assign stby_need = (GQW_STBY_W+1)'(GQW_STBY_BASE) +
                     {1'b0, standby_qual_count};

  always_comb begin
    next_st        = st;
    next_st.s1     = gpio_pin;
    next_st.s2     = st.s1;
    next_st.ext1   = {int_wake, watchdog_wake_int, nonmaskable_ext_int,
                      ~device_reset_pin};
    next_st.ext2   = st.ext1;
    next_st.gin    = (qual_q & qual_enable) | (unq_q & ~qual_enable);
    next_st.resume = 1'b0;
    // oscillator-rate enable: the oscillator runs at half the core clock
    next_st.osc_ph = ~st.osc_ph;
    next_st.osc_en = st.osc_ph;
    unique case (st.mode)
      GQW_RUN: begin
        next_st.guard = '0;
        next_st.wcnt  = '0;
        if (idle_enter) begin
          next_st.mode = standby_sel ? GQW_STBY : GQW_IDLE;
        end
      end
      GQW_IDLE, GQW_STBY: begin
        // wake sources are ignored until the guard interval has passed
        if (st.guard < 3'(GQW_LPM_GUARD)) begin
          if (st.osc_en) next_st.guard = st.guard + 3'h1;
        end else if (st.mode == GQW_IDLE) begin
          if (pin_wake || other_wake) begin
            next_st.mode = GQW_WAKE;
            next_st.lat  = wake_lat(flash_sleep);
          end
        end else begin
          // standby counts wake length in oscillator cycles
          if (!(pin_wake || other_wake)) begin
            next_st.wcnt = '0;
          end else if (st.osc_en) begin
            next_st.wcnt = st.wcnt + 7'h01;
          end
          if (st.wcnt >= (|(sel_pins & qual_enable) ? stby_need :
                          7'(GQW_STBY_UNQ))) begin
            next_st.mode = GQW_WAKE;
            next_st.lat  = wake_lat(flash_sleep);
          end
        end
      end
      GQW_WAKE: begin
        // resume marks the first instruction after idle, not the isr
        if (st.lat <= 11'h001) begin
          next_st.mode   = GQW_RUN;
          next_st.resume = 1'b1;
        end else begin
          next_st.lat = st.lat - 11'h001;
        end
      end
    endcase
    next_st.lpm = (next_st.mode != GQW_RUN);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign gpio_in    = st.gin;
  assign lpm_active = st.lpm;
  assign resume     = st.resume;

  sync_path_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##2 st.s2 == $past(gpio_pin, 2))
    else $error("pin synchroniser is not two stages");
  guard_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st.mode == GQW_IDLE && st.guard < 3'h4) |=> st.mode != GQW_WAKE)
    else $error("wake taken inside guard interval");
  fast_lat_a: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(st.mode == GQW_WAKE) && st.lat == 11'h010)
      |-> ##[1:16] st.resume)
    else $error("fast wake resume latency exceeded");
  idle_exit_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st.mode == GQW_IDLE && st.guard == 3'h4 && other_wake)
      |=> st.mode == GQW_WAKE)
    else $error("idle not exited on wake source");
endmodule

// ### verif/gqw_src.sv
// partner: source driving the eight pins on falling edges of sys_clk
`timescale 1ns/10ps
module gqw_src (
  input  wire logic       sys_clk,
  output logic      [7:0] gpio_pin
);
  initial gpio_pin = 8'h00;
  // holds a level for a count of clocks, then returns
  task automatic pulse(input logic [7:0] lvl, input int cyc);
    logic [7:0] old;
    old = gpio_pin;
    @(negedge sys_clk) gpio_pin = lvl;
    repeat (cyc) @(negedge sys_clk);
    gpio_pin = old;
  endtask
  // level change that is held until the next call
  task automatic set(input logic [7:0] lvl);
    @(negedge sys_clk) gpio_pin = lvl;
  endtask
endmodule

// ### verif/gqw_top_bench.sv
// bench: scenarios for the gpio input qualifier and wake block
`timescale 1ns/10ps
module gqw_top_bench;
  import gqw_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] gpio_pin, gpio_in;
  logic [7:0] qual_period_field = 8'h00;
  logic [7:0] qual_sample_select_reg = 8'h00;
  logic [7:0] qual_enable = 8'h00;
  logic [7:0] wake_pin_sel = 8'h00;
  logic [5:0] standby_qual_count = 6'h02;
  logic       idle_enter = 1'b0;
  logic       standby_sel = 1'b0;
  logic       flash_sleep = 1'b0;
  logic [3:0] src = 4'h0;
  logic       lpm_active, resume;
  wire        int_wake = src[0];
  wire        watchdog_wake_int = src[1];
  wire        nonmaskable_ext_int = src[2];
  wire        device_reset_pin = ~src[3];
  int         n_mismatch = 0;
  int         checks = 0;
  int         n;

  always #12.5 sys_clk = ~sys_clk;

  gqw_src u_gqw_src (.sys_clk, .gpio_pin);
  gqw_top u_gqw_top (.sys_clk, .rst, .gpio_pin, .qual_period_field,
    .qual_sample_select_reg, .qual_enable, .standby_qual_count,
    .idle_enter, .standby_sel, .flash_sleep, .int_wake, .watchdog_wake_int,
    .nonmaskable_ext_int, .device_reset_pin, .wake_pin_sel, .gpio_in,
    .lpm_active, .resume);

  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait on gpio_in or, with exp all ones on bit 8, on resume
  task automatic wait_for(input logic [8:0] exp, input int lim);
    n = 0;
    while (n < lim && (exp[8] ? resume !== 1'b1 : gpio_in !== exp[7:0]))
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, gpio_in, exp);
      close_out();
    end
  endtask

  task automatic sc_sync();
    u_gqw_src.set(8'ha5);
    wait_for({1'b0, 8'ha5}, 6);
    chk(n, 3);
  endtask

  // three samples at period zero: window of two cycles
  task automatic sc_three();
    @(negedge sys_clk) qual_enable = 8'hff;
    u_gqw_src.pulse(8'h5a, 1);
    repeat (8) @(negedge sys_clk);
    chk(gpio_in, 8'ha5);
    u_gqw_src.set(8'h3c);
    wait_for({1'b0, 8'h3c}, 9);
    chk(n >= 4, 1'b1);
  endtask

  // six samples at period two: window of twenty cycles
  task automatic sc_six();
    @(negedge sys_clk);
    qual_period_field = 8'h02;
    qual_sample_select_reg = 8'hff;
    u_gqw_src.pulse(8'hc3, 12);
    repeat (30) @(negedge sys_clk);
    chk(gpio_in, 8'h3c);
    u_gqw_src.set(8'hc3);
    wait_for({1'b0, 8'hc3}, 34);
    chk(n >= 20, 1'b1);
  endtask

  // three samples at period one: a sample every two cycles
  task automatic sc_prd1();
    @(negedge sys_clk);
    qual_period_field = 8'h01;
    qual_sample_select_reg = 8'h00;
    repeat (8) @(negedge sys_clk);
    u_gqw_src.set(8'h5a);
    wait_for({1'b0, 8'h5a}, 12);
    chk(n >= 6 && n <= 10, 1'b1);
  endtask

  // latency counted from the rising edge of the wake source
  task automatic sc_wake(input logic sb, input logic [3:0] s,
                         input logic [7:0] pin, input logic fs,
                         input int hold, input int lo, input int lim);
    @(negedge sys_clk);
    standby_sel = sb;
    flash_sleep = fs;
    wake_pin_sel = pin;
    idle_enter = 1'b1;
    @(negedge sys_clk) idle_enter = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk(lpm_active, 1'b1);
    fork
      u_gqw_src.pulse(pin, hold);
    join_none
    @(negedge sys_clk) src = s;
    n = 0;
    while (n < lim && resume !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n == hold) src = 4'h0;
    end
    if (resume !== 1'b1) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, n, lim);
      close_out();
    end
    chk(n >= lo, 1'b1);
    chk({resume, lpm_active}, 2'b10);
    @(negedge sys_clk);
    chk({resume, lpm_active}, 2'b00);
  endtask

  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    sc_sync();
    sc_three();
    sc_six();
    sc_prd1();
    @(negedge sys_clk) qual_enable = 8'h00;
    u_gqw_src.set(8'h00);
    repeat (6) @(negedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      sc_wake(1'b0, 4'h1 << k, 8'h00, 1'b0, 2, 1, 20);
    end
    sc_wake(1'b0, 4'h1, 8'h00, 1'b1, 2, 1000, 1050);
    sc_wake(1'b1, 4'h0, 8'h01, 1'b0, 6, 1, 60);
    @(negedge sys_clk);
    qual_period_field = 8'h00;
    qual_enable = 8'h01;
    repeat (6) @(negedge sys_clk);
    sc_wake(1'b1, 4'h0, 8'h01, 1'b0, 8, 1, 60);
    close_out();
  end
endmodule
